// [hw/fpep_params.svh]
// Offsets, field positions, reset values and counts of the flash sequencer.
// Assumes a 16-bit processor address space with the array in its upper half.
`ifndef FPEP_PARAMS_SVH
`define FPEP_PARAMS_SVH
`define FPEP_PROT_OFS 16'hff80
`define FPEP_CTRL_OFS 16'hff88
`define FPEP_STAT_OFS 16'hff8a
`define FPEP_ARRAY_MSB 15
`define FPEP_HIGH_VOLTAGE_ENABLE_BIT 3
`define FPEP_MASS_BIT 2
`define FPEP_ERASE_BIT 1
`define FPEP_PGM_BIT 0
`define FPEP_BP_NONE 8'hff
`define FPEP_BP_TOP2 8'hfe
`define FPEP_BP_RST 8'h00
`define FPEP_TOP2_START 16'hff00
`define FPEP_ERASED 8'hff
`define FPEP_ROW_LSB 6
`define FPEP_PAGE_LSB 7
`define FPEP_PAGE_LAST 7'h7f
`define FPEP_MASS_LAST 15'h7fff
`endif

// [hw/fpep_pkg.sv]
// Types shared by the flash sequencer files.
// Assumes fpep_params.svh is compiled alongside.
`default_nettype none
package fpep_pkg;
  typedef enum logic [2:0] {
    FPEP_IDLE = 3'b000,
    FPEP_ARMED = 3'b001,
    FPEP_BP_SEEN = 3'b011,
    FPEP_LATCHED = 3'b010,
    FPEP_ERASING = 3'b110,
    FPEP_HV_ON = 3'b111,
    FPEP_LOAD = 3'b100,
    FPEP_LOAD2 = 3'b101
  } fpep_seq_type;

  typedef struct packed {
    fpep_seq_type seq;
    logic high_voltage_enable;
    logic mass;
    logic erase;
    logic program_select;
    logic [7:0] bp;
    logic [14:0] lat;
    logic [14:0] cnt;
    logic fail;
    logic standby;
  } fpep_state_type;
endpackage
`default_nettype wire

// [hw/fpep_array.sv]
// Byte array behind the sequencer with a registered read port.
// Assumes one write per cycle; a write in and-mode can only clear bits.
`default_nettype none
module fpep_array #(
  parameter int ADDR_W = 15,
  parameter logic [7:0] INIT_BYTE = 8'hff
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic ovr_en,
  input wire logic [7:0] ovr_data,
  output logic [7:0] rd_data,
  input wire logic wr_en,
  input wire logic wr_and,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [7:0] wr_data
);
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  logic [7:0] rd_data_r;

  // Cells start erased, as a fresh part would
  initial begin
    for (int i = 0; i < (1<<ADDR_W); i++) begin
      mem[i] = INIT_BYTE;
    end
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_and ? (mem[wr_addr] & wr_data) : wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= ovr_en ? ovr_data : mem[rd_addr];
    end
  end

  assign rd_data = rd_data_r;
endmodule
`default_nettype wire

// [hw/fpep_sequencer.sv]
// Flash program/erase control with block protection, on the CPU bus clock.
// Assumes a single-cycle strobe bus and a low-power request from the same clock.
`default_nettype none
`include "fpep_params.svh"
module fpep_sequencer (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic low_power_req,
  output logic charge_pump_on,
  output logic flash_standby
);
  fpep_pkg::fpep_state_type st_r;
  fpep_pkg::fpep_state_type st_nxt;
  logic [14:0] mem_ra;
  logic mem_ovr;
  logic [7:0] mem_ovr_data;
  logic mem_we;
  logic mem_and;
  logic [14:0] mem_wa;
  logic [7:0] mem_wd;
  logic arr_acc;
  logic is_ctrl;
  logic is_stat;
  logic new_erase;
  logic new_pgm;
  logic [14:0] eng_addr;
  logic eng_last;

  // Protected when at or above the start address; no check of physical existence
  function automatic logic is_prot(input logic [15:0] a, input logic [7:0] bp);
    logic [15:0] start;
    start = {1'b1, bp, 7'h00};
    if (bp == `FPEP_BP_TOP2) begin
      start = `FPEP_TOP2_START;
    end
    if (bp == `FPEP_BP_NONE) begin
      return 1'b0;
    end
    return a >= start;
  endfunction

  assign is_ctrl = (addr == `FPEP_CTRL_OFS);
  assign is_stat = (addr == `FPEP_STAT_OFS);
  assign arr_acc = addr[`FPEP_ARRAY_MSB] && !is_ctrl && !is_stat;
  assign eng_addr = st_r.mass ? st_r.cnt : {st_r.lat[14:`FPEP_PAGE_LSB], st_r.cnt[6:0]};
  assign eng_last = st_r.mass ? (st_r.cnt == `FPEP_MASS_LAST)
                              : (st_r.cnt[6:0] == `FPEP_PAGE_LAST);

  always_comb begin
    st_nxt = st_r;
    mem_ra = addr[14:0];
    mem_ovr = 1'b0;
    mem_ovr_data = 8'h00;
    mem_we = 1'b0;
    mem_and = 1'b0;
    mem_wa = addr[14:0];
    mem_wd = wdata;
    new_erase = wdata[`FPEP_ERASE_BIT];
    new_pgm = wdata[`FPEP_PGM_BIT];
    st_nxt.standby = low_power_req;

    // Read side: registers and unmapped space bypass the array
    if (rd && !arr_acc) begin
      mem_ovr = 1'b1;
      if (is_ctrl) begin
        mem_ovr_data = {4'h0, st_r.high_voltage_enable, st_r.mass, st_r.erase, st_r.program_select};
      end else if (is_stat) begin
        mem_ovr_data = {3'b000, st_r.fail, 1'b0, st_r.seq};
      end
    end

    unique case (st_r.seq)
      fpep_pkg::FPEP_LOAD: begin
        // Protect byte is only readable from the array, so fetch it after reset
        mem_ra = 15'(`FPEP_PROT_OFS);
        mem_ovr = 1'b0;
        st_nxt.seq = fpep_pkg::FPEP_LOAD2;
      end
      fpep_pkg::FPEP_LOAD2: begin
        st_nxt.bp = rdata;
        st_nxt.seq = fpep_pkg::FPEP_IDLE;
      end
      fpep_pkg::FPEP_IDLE: begin
        st_nxt.fail = 1'b0;
        if (st_r.erase || st_r.program_select) begin
          st_nxt.seq = fpep_pkg::FPEP_ARMED;
        end
      end
      fpep_pkg::FPEP_ARMED: begin
        if (rd && addr == `FPEP_PROT_OFS) begin
          st_nxt.seq = fpep_pkg::FPEP_BP_SEEN;
        end
      end
      fpep_pkg::FPEP_BP_SEEN: begin
        // A protected target is simply not latched, so nothing can follow
        if (wr && arr_acc && !is_prot(addr, st_r.bp)) begin
          st_nxt.lat = addr[14:0];
          st_nxt.seq = fpep_pkg::FPEP_LATCHED;
        end
      end
      fpep_pkg::FPEP_LATCHED: begin
      end
      fpep_pkg::FPEP_ERASING: begin
        mem_wa = eng_addr;
        mem_wd = `FPEP_ERASED;
        mem_we = !is_prot({1'b1, eng_addr}, st_r.bp);
        if (mem_we && {1'b1, eng_addr} == `FPEP_PROT_OFS) begin
          st_nxt.bp = `FPEP_ERASED;
        end
        st_nxt.cnt = st_r.cnt + 15'h0001;
        if (eng_last) begin
          st_nxt.seq = fpep_pkg::FPEP_HV_ON;
        end
      end
      fpep_pkg::FPEP_HV_ON: begin
        if (wr && arr_acc && st_r.program_select) begin
          if (st_r.fail || addr[14:`FPEP_ROW_LSB] != st_r.lat[14:`FPEP_ROW_LSB]
              || is_prot(addr, st_r.bp)) begin
            st_nxt.fail = 1'b1;
          end else begin
            mem_we = 1'b1;
            mem_and = 1'b1;
            if (addr == `FPEP_PROT_OFS) begin
              st_nxt.bp = st_r.bp & wdata;
            end
          end
        end
      end
    endcase

    // Control register write
    if (wr && is_ctrl && st_r.seq != fpep_pkg::FPEP_LOAD
        && st_r.seq != fpep_pkg::FPEP_LOAD2) begin
      if (new_erase && new_pgm) begin
        new_erase = st_r.erase;
        new_pgm = st_r.program_select;
      end
      st_nxt.erase = new_erase;
      st_nxt.program_select = new_pgm;
      st_nxt.mass = wdata[`FPEP_MASS_BIT];
      if (!wdata[`FPEP_HIGH_VOLTAGE_ENABLE_BIT]) begin
        st_nxt.high_voltage_enable = 1'b0;
      end else if (!st_r.high_voltage_enable && st_r.seq == fpep_pkg::FPEP_LATCHED
                   && (new_erase || new_pgm)
                   && !is_prot({1'b1, st_r.lat}, st_r.bp)) begin
        st_nxt.high_voltage_enable = 1'b1;
        st_nxt.cnt = 15'h0000;
        st_nxt.seq = new_erase ? fpep_pkg::FPEP_ERASING : fpep_pkg::FPEP_HV_ON;
      end
      if (!new_erase && !new_pgm && !st_nxt.high_voltage_enable) begin
        st_nxt.seq = fpep_pkg::FPEP_IDLE;
      end
    end

    // Wait or stop: drop the pump and abandon the operation
    if (low_power_req && st_r.seq != fpep_pkg::FPEP_LOAD
        && st_r.seq != fpep_pkg::FPEP_LOAD2) begin
      st_nxt.high_voltage_enable = 1'b0;
      st_nxt.seq = fpep_pkg::FPEP_IDLE;
      mem_we = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r.seq <= fpep_pkg::FPEP_LOAD;
      st_r.high_voltage_enable <= 1'b0;
      st_r.mass <= 1'b0;
      st_r.erase <= 1'b0;
      st_r.program_select <= 1'b0;
      st_r.bp <= `FPEP_BP_RST;
      st_r.lat <= 15'h0000;
      st_r.cnt <= 15'h0000;
      st_r.fail <= 1'b0;
      st_r.standby <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  fpep_array #(
    .ADDR_W(15),
    .INIT_BYTE(`FPEP_ERASED)
  ) u_array (
    .clk(clk),
    .reset(reset),
    .rd_addr(mem_ra),
    .ovr_en(mem_ovr),
    .ovr_data(mem_ovr_data),
    .rd_data(rdata),
    .wr_en(mem_we),
    .wr_and(mem_and),
    .wr_addr(mem_wa),
    .wr_data(mem_wd)
  );

  assign charge_pump_on = st_r.high_voltage_enable;
  assign flash_standby = st_r.standby;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  select_interlock_a: assert property (!(st_r.erase && st_r.program_select))
    else $error("Erase and program selected together");
  high_voltage_enable_needs_select_a: assert property ($rose(st_r.high_voltage_enable) |-> (st_r.erase || st_r.program_select))
    else $error("High voltage without a selected operation");
  high_voltage_enable_after_latch_a: assert property ($rose(st_r.high_voltage_enable) |-> $past(st_r.seq) == fpep_pkg::FPEP_LATCHED)
    else $error("High voltage outside the ordered sequence");
  high_voltage_enable_unprotected_a: assert property ($rose(st_r.high_voltage_enable) |-> !is_prot({1'b1, st_r.lat}, st_r.bp))
    else $error("High voltage on a protected target");
  latch_unprotected_a: assert property (
    st_r.seq == fpep_pkg::FPEP_LATCHED && $past(st_r.seq) == fpep_pkg::FPEP_BP_SEEN
    |-> !is_prot({1'b1, st_r.lat}, st_r.bp))
    else $error("Protected address latched as target");
  reset_clear_a: assert property ($past(reset) |-> !st_r.high_voltage_enable && !st_r.erase && !st_r.program_select)
    else $error("Control bits not clear after reset");
  standby_off_a: assert property (low_power_req && st_r.seq != fpep_pkg::FPEP_LOAD
    && st_r.seq != fpep_pkg::FPEP_LOAD2
    |=> !st_r.high_voltage_enable && st_r.seq == fpep_pkg::FPEP_IDLE ##0 flash_standby)
    else $error("Low power did not suspend the operation");
  page_scope_a: assert property (mem_we && !mem_and && !st_r.mass
    |-> mem_wa[14:7] == st_r.lat[14:7])
    else $error("Page erase left its page");
  row_scope_a: assert property (mem_we && mem_and |-> mem_wa[14:6] == st_r.lat[14:6])
    else $error("Program write outside the latched row");
  write_unprotected_a: assert property (mem_we |-> !is_prot({1'b1, mem_wa}, st_r.bp))
    else $error("Array write inside protected range");

  page_erase_c: cover property (st_r.seq == fpep_pkg::FPEP_ERASING && !st_r.mass ##1
    st_r.seq == fpep_pkg::FPEP_HV_ON);
  mass_erase_c: cover property ($rose(st_r.high_voltage_enable) && st_r.erase && st_r.mass);
  program_c: cover property (mem_we && mem_and);
  row_fail_c: cover property ($rose(st_r.fail));
endmodule
`default_nettype wire

// [verification/fpep_testbench.sv]
// Self-checking bench for the flash sequencer: control bits, program, erase, protection.
// Assumes an erased array at power-up and the strobe bus described for the sequencer.
`default_nettype none
`include "fpep_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic low_power_req = 1'b0;
  logic [7:0] rdata;
  logic charge_pump_on;
  logic flash_standby;
  logic [7:0] got;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  fpep_sequencer DUT (
    .clk(clk),
    .reset(reset),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .low_power_req(low_power_req),
    .charge_pump_on(charge_pump_on),
    .flash_standby(flash_standby)
  );

  task automatic results;
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Ceiling is several times the longest expected run, a page erase included
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      results();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Register read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic arm(input logic [7:0] mode, input logic [15:0] a, input logic pump);
    wr_reg(`FPEP_CTRL_OFS, mode);
    rd_reg(`FPEP_PROT_OFS, got);
    wr_reg(a, 8'h00);
    wr_reg(`FPEP_CTRL_OFS, mode | 8'h08);
    #1;
    check({7'h00, charge_pump_on}, {7'h00, pump}, "pump after enable");
  endtask

  task automatic finish_op;
    wr_reg(`FPEP_CTRL_OFS, 8'h08);
    wr_reg(`FPEP_CTRL_OFS, 8'h00);
  endtask

  task automatic prog(input logic [15:0] a, input logic [7:0] d);
    arm(8'h01, a, 1'b1);
    wr_reg(a, d);
    finish_op();
  endtask

  task automatic t_reset_state;
    rd_reg(`FPEP_CTRL_OFS, got);
    check(got, 8'h00, "control after reset");
    check({7'h00, charge_pump_on}, 8'h00, "pump after reset");
    rd_reg(16'h8000, got);
    check(got, 8'hff, "first byte erased");
    rd_reg(16'hfdff, got);
    check(got, 8'hff, "last user byte erased");
  endtask

  task automatic t_control_bits;
    wr_reg(`FPEP_CTRL_OFS, 8'h08);
    rd_reg(`FPEP_CTRL_OFS, got);
    check(got, 8'h00, "enable without sequence");
    wr_reg(`FPEP_CTRL_OFS, 8'h06);
    rd_reg(`FPEP_CTRL_OFS, got);
    check(got, 8'h06, "mass erase select");
    wr_reg(`FPEP_CTRL_OFS, 8'h03);
    rd_reg(`FPEP_CTRL_OFS, got);
    // Clashing selects keep the old erase and program bits; mass follows the write
    check(got, 8'h02, "erase and program together");
    wr_reg(`FPEP_CTRL_OFS, 8'h00);
  endtask

  task automatic t_program_erase;
    prog(16'h9000, 8'h5a);
    rd_reg(16'h9000, got);
    check(got, 8'h5a, "programmed byte");
    rd_reg(16'h903f, got);
    check(got, 8'hff, "neighbour untouched");
    // Latch address at the page's last byte still selects the whole page
    arm(8'h02, 16'h907f, 1'b1);
    repeat (135) @(posedge clk);
    finish_op();
    rd_reg(16'h9000, got);
    check(got, 8'hff, "page erased");
  endtask

  task automatic t_row_fail;
    arm(8'h01, 16'h9100, 1'b1);
    wr_reg(16'h9100, 8'h00);
    wr_reg(16'h9140, 8'h00);
    rd_reg(`FPEP_STAT_OFS, got);
    check(got & 8'h10, 8'h10, "row violation flagged");
    rd_reg(16'h9140, got);
    check(got, 8'hff, "other row not written");
    finish_op();
  endtask

  task automatic t_low_power;
    arm(8'h01, 16'ha000, 1'b1);
    @(posedge clk);
    low_power_req <= 1'b1;
    @(posedge clk);
    #1;
    check({7'h00, charge_pump_on}, 8'h00, "pump off in low power");
    check({7'h00, flash_standby}, 8'h01, "standby in low power");
    @(posedge clk);
    low_power_req <= 1'b0;
    wr_reg(`FPEP_CTRL_OFS, 8'h00);
  endtask

  task automatic t_protect;
    prog(`FPEP_PROT_OFS, 8'hfe);
    wr_reg(`FPEP_PROT_OFS, 8'h00);
    rd_reg(`FPEP_PROT_OFS, got);
    check(got, 8'hfe, "protect byte only by programming");
    arm(8'h01, 16'hff00, 1'b0);
    wr_reg(`FPEP_CTRL_OFS, 8'h00);
    prog(16'hfe80, 8'h33);
    rd_reg(16'hfe80, got);
    check(got, 8'h33, "page below range open");
  endtask

  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset_state();
    t_control_bits();
    t_program_erase();
    t_row_fail();
    t_low_power();
    t_protect();
    results();
  end
endmodule
`default_nettype wire
